// *** pkg/acr_pkg.sv ***
// Constants, field layouts and carrier types for the converter control register set.
// How it works
// R1: Writing start high then low launches exactly one conversion on the falling write.
// R2: Busy flag sets at launch, clears at completion; writes to it are ignored.
// R3: Enable low powers the converter down; high allows conversions.
// R4: While disabled, both result registers keep their contents.
// R5: Justify 0 puts bits 11:4 high, 3:0 low; 1 puts 11:8 high, 7:0 low.
// R6: Left-justified low bits sit at 7:4; every unused result bit reads zero.
// R7: Channel codes 0,1,5-8,9,11 route channels 0,1,5-8,9,11.
// R8: Software never writes reserved channel codes 0010, 0011, 0100, 1010.
// R9: Channel codes 1100 to 1111 connect no channel; input floats.
// R10: Source 0000,0100,11xx picks external; 0001-0011 supply divided by 1,2,4.
// R11: Source 0101-0111 picks amplifier output /1,/2,/4; 10xx grounds the input.
// R12: Any internal source disconnects the external channel path.
// R13: Conversion clock equals system clock divided by two to the field value.
// R14: Unimplemented control bits read zero and ignore writes.
// R15: Software enables the amplifier whenever its output is used.
// R16: Amplifier input select 1 routes bandgap; 0 is reserved.
// R17: Reference 00 supply, 01 external pin, 1x amplifier output.
// R18: Internal reference disconnects the external reference pin path.
// R19: Gain codes 00..11 give gains 1, 1.667, 2.5, 3.333.
// R20: Software enables bandgap and waits for settling before using it.
// R21: Pins used as converter inputs lose other functions and pull-highs.
// R22: Completion sets the converter interrupt request flag and clears busy.
// R23: Start sequences during a conversion are ignored; results update together.
// R24: All control fields, busy and bandgap enable clear on reset.
package acr_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL0  = 8'h00;
	localparam logic [7:0] ADDR_CTRL1  = 8'h04;
	localparam logic [7:0] ADDR_CTRL2  = 8'h08;
	localparam logic [7:0] ADDR_BGAP   = 8'h0C;
	localparam logic [7:0] ADDR_RESH   = 8'h10;
	localparam logic [7:0] ADDR_RESL   = 8'h14;
	localparam logic [7:0] ADDR_STATUS = 8'h18;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int C0_START  = 7;
	localparam int C0_BUSY   = 6;
	localparam int C0_EN     = 5;
	localparam int C0_JUST   = 4;
	localparam int C2_AMPEN  = 7;
	localparam int C2_AMPIN  = 4;
	localparam int ST_IRQ    = 0;

	// Writable masks and reset values.
	localparam logic [7:0] C0_WMASK = 8'hBF;
	localparam logic [7:0] C1_WMASK = 8'hF7;
	localparam logic [7:0] C2_WMASK = 8'h9F;
	localparam logic [7:0] BG_WMASK = 8'h01;
	localparam logic [7:0] REG_RST  = 8'h00;

	// Default conversion length in conversion clocks.
	localparam int CONV_CLKS = 16;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		ACR_REF_SUPPLY,
		ACR_REF_PIN,
		ACR_REF_AMP
	} acr_ref_t;

	typedef enum logic [2:0] {
		ACR_IN_EXT,
		ACR_IN_SUPPLY,
		ACR_IN_AMP,
		ACR_IN_GND
	} acr_insrc_t;

	typedef struct packed {
		logic        conv_power;
		logic        conv_clk_en;
		logic        conv_sample;
		logic        ext_connect;
		logic [3:0]  ext_channel;
		logic [2:0]  in_source;
		logic [1:0]  in_divide;
		logic        ref_pin_connect;
		logic [1:0]  ref_source;
		logic        amp_enable;
		logic        amp_bandgap;
		logic [1:0]  amp_gain;
		logic        bandgap_enable;
		logic [11:0] pin_analog;
	} acr_analog_t;

endpackage : acr_pkg

// *** hw/acr_route_dec.sv ***
// Decoder for the converter input and reference multiplexer selects.
`timescale 1ns/10ps
`default_nettype none
module acr_route_dec (
	input  wire logic [3:0]  ext_channel_sel,
	input  wire logic [3:0]  input_source_sel,
	input  wire logic [1:0]  reference_sel,
	output var  logic        ext_connect,
	output var  logic [11:0] pin_analog,
	output var  logic [2:0]  in_source,
	output var  logic [1:0]  in_divide,
	output var  logic [1:0]  ref_source,
	output var  logic        ref_pin_connect
);
	import acr_pkg::*;

	logic chan_valid;

	always_comb begin
		chan_valid = 1'b0;
		case (ext_channel_sel)
			4'h0, 4'h1, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hB: chan_valid = 1'b1; // R7 R9
			default: chan_valid = 1'b0;
		endcase
		in_source = ACR_IN_EXT;
		in_divide = 2'h0;
		casez (input_source_sel)
			4'b0000, 4'b0100, 4'b11??: in_source = ACR_IN_EXT; // R10
			4'b0001, 4'b0010, 4'b0011: begin
				in_source = ACR_IN_SUPPLY; // R10
				in_divide = 2'(input_source_sel[1:0] - 2'h1);
			end
			4'b0101, 4'b0110, 4'b0111: begin
				in_source = ACR_IN_AMP; // R11
				in_divide = 2'(input_source_sel[1:0] - 2'h1);
			end
			4'b10??: in_source = ACR_IN_GND; // R11
			default: in_source = ACR_IN_EXT;
		endcase
		ext_connect = chan_valid && (in_source == ACR_IN_EXT); // R12
		pin_analog = 12'h000;
		if (ext_connect) begin
			pin_analog[ext_channel_sel] = 1'b1; // R21
		end
		case (reference_sel)
			2'b00:   ref_source = ACR_REF_SUPPLY; // R17
			2'b01:   ref_source = ACR_REF_PIN;
			default: ref_source = ACR_REF_AMP;
		endcase
		ref_pin_connect = (reference_sel == 2'b01); // R18
	end

endmodule : acr_route_dec
`default_nettype wire

// *** hw/acr_ctrl.sv ***
// Converter control register set with APB slave, prescaler and conversion sequencer.
`timescale 1ns/10ps
`default_nettype none
module acr_ctrl #(
	parameter int CONV_LEN = acr_pkg::CONV_CLKS
) (
	input  wire logic               pclk,
	input  wire logic               presetn,
	input  wire logic               clk_en,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output var  logic [31:0]        prdata,
	output var  logic               pready,
	output var  logic               pslverr,
	input  wire logic               conv_done,
	input  wire logic [11:0]        conv_data,
	output var  acr_pkg::acr_analog_t analog_ctl,
	output var  logic               conv_irq_req
);
	import acr_pkg::*;

	if (CONV_LEN < 1 || CONV_LEN > 255) begin : g_len_check
		$error("CONV_LEN out of range");
	end

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef enum {
		ACR_IDLE,
		ACR_CONV
	} acr_state_t;

	acr_state_t  state_r, state_nxt;
	logic [7:0]  ctrl0_r, ctrl0_nxt;
	logic [7:0]  ctrl1_r, ctrl1_nxt;
	logic [7:0]  ctrl2_r, ctrl2_nxt;
	logic [7:0]  bgap_r, bgap_nxt;
	logic [11:0] result_r, result_nxt;
	logic        irq_r, irq_nxt;
	logic [6:0]  presc_r, presc_nxt;
	logic [7:0]  cnt_r, cnt_nxt;
	logic        done_s1_r, done_s2_r, done_s3_r;
	logic [11:0] data_s1_r, data_s2_r;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt;
	logic        pslverr_r, pslverr_nxt;
	acr_analog_t analog_r, analog_nxt;

	logic        acc;
	logic        wr;
	logic        start_fall;
	logic        tick;
	logic        done_evt;
	logic        mapped;
	logic [7:0]  wbyte;
	logic [7:0]  res_hi;
	logic [7:0]  res_lo;
	logic        ext_connect;
	logic [11:0] pin_analog;
	logic [2:0]  in_source;
	logic [1:0]  in_divide;
	logic [1:0]  ref_source;
	logic        ref_pin_connect;

	// ------------------------------------------------------------
	// Multiplexer decode
	// ------------------------------------------------------------
	acr_route_dec u_dec (
		.ext_channel_sel  (ctrl0_r[3:0]),
		.input_source_sel (ctrl1_r[7:4]),
		.reference_sel    (ctrl2_r[3:2]),
		.ext_connect      (ext_connect),
		.pin_analog       (pin_analog),
		.in_source        (in_source),
		.in_divide        (in_divide),
		.ref_source       (ref_source),
		.ref_pin_connect  (ref_pin_connect)
	);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------
	always_comb begin
		acc    = psel && penable && !pready_r;
		// Writes land at the edge where the master samples pready high.
		wr     = psel && penable && pready_r && pwrite;
		wbyte  = pwdata[7:0];
		mapped = (paddr == ADDR_CTRL0) || (paddr == ADDR_CTRL1) || (paddr == ADDR_CTRL2) ||
			(paddr == ADDR_BGAP) || (paddr == ADDR_RESH) || (paddr == ADDR_RESL) ||
			(paddr == ADDR_STATUS);

		// Result justification.
		if (ctrl0_r[C0_JUST]) begin
			res_hi = {4'h0, result_r[11:8]}; // R5 R6
			res_lo = result_r[7:0];
		end else begin
			res_hi = result_r[11:4]; // R5
			res_lo = {result_r[3:0], 4'h0}; // R6
		end

		ctrl0_nxt = ctrl0_r;
		ctrl1_nxt = ctrl1_r;
		ctrl2_nxt = ctrl2_r;
		bgap_nxt  = bgap_r;
		if (wr && paddr == ADDR_CTRL0) begin
			ctrl0_nxt = (wbyte & C0_WMASK) | (ctrl0_r & ~C0_WMASK); // R2 R14
		end
		if (wr && paddr == ADDR_CTRL1) begin
			ctrl1_nxt = wbyte & C1_WMASK; // R14
		end
		if (wr && paddr == ADDR_CTRL2) begin
			ctrl2_nxt = wbyte & C2_WMASK; // R14
		end
		if (wr && paddr == ADDR_BGAP) begin
			bgap_nxt = wbyte & BG_WMASK; // R14
		end
		start_fall = ctrl0_r[C0_START] && !ctrl0_nxt[C0_START]; // R1

		// Prescaler: tick every 2**sel system clocks.
		presc_nxt = presc_r + 7'h01;
		tick      = ((presc_r & 7'((8'h01 << ctrl1_r[2:0]) - 8'h01)) == 7'h00); // R13
		if (!ctrl0_r[C0_EN]) begin
			presc_nxt = 7'h00;
		end

		// Conversion sequencer.
		state_nxt  = state_r;
		cnt_nxt    = cnt_r;
		result_nxt = result_r;
		irq_nxt    = irq_r;
		done_evt   = 1'b0;
		case (state_r)
			ACR_IDLE: begin
				if (start_fall && ctrl0_r[C0_EN]) begin
					state_nxt = ACR_CONV; // R1
					cnt_nxt   = 8'(CONV_LEN);
					ctrl0_nxt[C0_BUSY] = 1'b1; // R2
				end
			end
			ACR_CONV: begin
				if (!ctrl0_r[C0_EN]) begin
					state_nxt = ACR_IDLE; // R3 R4
					ctrl0_nxt[C0_BUSY] = 1'b0;
				end else begin
					if (tick && cnt_r != 8'h00) begin
						cnt_nxt = cnt_r - 8'h01;
					end
					if (cnt_r == 8'h00 && done_s2_r && !done_s3_r) begin
						done_evt   = 1'b1;
						state_nxt  = ACR_IDLE;
						result_nxt = data_s2_r; // R23
						ctrl0_nxt[C0_BUSY] = 1'b0; // R2 R22
					end
				end
			end
			default: state_nxt = ACR_IDLE;
		endcase

		// Sticky request: a completion in the clearing cycle wins.
		if (wr && paddr == ADDR_STATUS && wbyte[ST_IRQ]) begin
			irq_nxt = 1'b0;
		end
		if (done_evt) begin
			irq_nxt = 1'b1; // R22
		end

		// APB read and answer.
		pready_nxt  = acc;
		pslverr_nxt = acc && !mapped;
		prdata_nxt  = prdata_r;
		if (acc && !pwrite) begin
			case (paddr)
				ADDR_CTRL0:  prdata_nxt = {24'h0, ctrl0_r};
				ADDR_CTRL1:  prdata_nxt = {24'h0, ctrl1_r};
				ADDR_CTRL2:  prdata_nxt = {24'h0, ctrl2_r};
				ADDR_BGAP:   prdata_nxt = {24'h0, bgap_r};
				ADDR_RESH:   prdata_nxt = {24'h0, res_hi};
				ADDR_RESL:   prdata_nxt = {24'h0, res_lo};
				ADDR_STATUS: prdata_nxt = {31'h0, irq_r};
				default:     prdata_nxt = 32'h0;
			endcase
		end

		// Analog control word.
		analog_nxt.conv_power      = ctrl0_r[C0_EN]; // R3
		analog_nxt.conv_clk_en     = ctrl0_r[C0_EN] && tick;
		analog_nxt.conv_sample     = (state_r == ACR_CONV);
		analog_nxt.ext_connect     = ext_connect; // R12
		analog_nxt.ext_channel     = ctrl0_r[3:0];
		analog_nxt.in_source       = in_source;
		analog_nxt.in_divide       = in_divide;
		analog_nxt.ref_pin_connect = ref_pin_connect; // R18
		analog_nxt.ref_source      = ref_source;
		analog_nxt.amp_enable      = ctrl2_r[C2_AMPEN];
		analog_nxt.amp_bandgap     = ctrl2_r[C2_AMPIN]; // R16
		analog_nxt.amp_gain        = ctrl2_r[1:0]; // R19
		analog_nxt.bandgap_enable  = bgap_r[0];
		analog_nxt.pin_analog      = pin_analog; // R21
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r   <= ACR_IDLE;
			ctrl0_r   <= REG_RST; // R24
			ctrl1_r   <= REG_RST;
			ctrl2_r   <= REG_RST;
			bgap_r    <= REG_RST;
			result_r  <= 12'h000;
			irq_r     <= 1'b0;
			presc_r   <= 7'h00;
			cnt_r     <= 8'h00;
			done_s1_r <= 1'b0;
			done_s2_r <= 1'b0;
			done_s3_r <= 1'b0;
			data_s1_r <= 12'h000;
			data_s2_r <= 12'h000;
			prdata_r  <= 32'h0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			analog_r  <= '0;
		end else if (clk_en) begin
			state_r   <= state_nxt;
			ctrl0_r   <= ctrl0_nxt;
			ctrl1_r   <= ctrl1_nxt;
			ctrl2_r   <= ctrl2_nxt;
			bgap_r    <= bgap_nxt;
			result_r  <= result_nxt;
			irq_r     <= irq_nxt;
			presc_r   <= presc_nxt;
			cnt_r     <= cnt_nxt;
			done_s1_r <= conv_done;
			done_s2_r <= done_s1_r;
			done_s3_r <= done_s2_r;
			data_s1_r <= conv_data;
			data_s2_r <= data_s1_r;
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			analog_r  <= analog_nxt;
		end
	end

	assign prdata       = prdata_r;
	assign pready       = pready_r;
	assign pslverr      = pslverr_r;
	assign analog_ctl   = analog_r;
	assign conv_irq_req = irq_r;

endmodule : acr_ctrl
`default_nettype wire

// *** tb/acr_core_model.sv ***
// Behavioural model of the analog converter core behind the control block.
`timescale 1ns/10ps
`default_nettype none
module acr_core_model #(
	parameter int LEN = 2
) (
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire acr_pkg::acr_analog_t ctl,
	input  wire logic [11:0]          value,
	input  wire logic [7:0]           extra,
	output logic                      conv_done,
	output logic [11:0]               conv_data
);
	import acr_pkg::*;
	int n;
	int ticks;
	// Data is loaded at the start of sampling so it is stable well before done rises.
	// Outside a conversion the data lines toggle, so a stale result never looks valid.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			n         <= 0;
			ticks     <= 0;
			conv_done <= 1'b0;
			conv_data <= 12'h000;
		end else if (ctl.conv_sample) begin
			if (n == 0) conv_data <= value;
			n <= n + 1;
			if (ctl.conv_clk_en) ticks <= ticks + 1;
			conv_done <= (ticks >= LEN) && (n >= 4 + int'(extra));
		end else begin
			n         <= 0;
			ticks     <= 0;
			conv_done <= 1'b0;
			conv_data <= ~conv_data;
		end
	end
endmodule : acr_core_model
`default_nettype wire

// *** tb/acr_checker.sv ***
// Port-level assertions for the converter control register set.
`timescale 1ns/10ps
`default_nettype none
module acr_checker (
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [7:0]           paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire acr_pkg::acr_analog_t analog_ctl,
	input wire logic                 conv_irq_req
);
	import acr_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_rd_zero;
		pready |-> prdata[31:8] == 24'h000000;
	endproperty
	a_rd_zero: assert property (p_rd_zero) else $error("read data upper bits set");
	property p_busy_rd;
		pready && !pwrite && paddr == ADDR_CTRL0 |-> prdata[C0_BUSY] == analog_ctl.conv_sample;
	endproperty
	a_busy_rd: assert property (p_busy_rd) else $error("busy read differs from conversion state");
	property p_start_wr;
		$rose(analog_ctl.conv_sample) |-> $past(psel && pwrite && paddr == ADDR_CTRL0 && !pwdata[C0_START], 2);
	endproperty
	a_start_wr: assert property (p_start_wr) else $error("conversion began without start release");
	property p_irq_done;
		$rose(conv_irq_req) |=> $fell(analog_ctl.conv_sample);
	endproperty
	a_irq_done: assert property (p_irq_done) else $error("request flag set without completion");
	property p_irq_hold;
		conv_irq_req && !(psel && penable && pready && pwrite && paddr == ADDR_STATUS && pwdata[ST_IRQ])
			|=> conv_irq_req;
	endproperty
	a_irq_hold: assert property (p_irq_hold) else $error("request flag dropped on its own");
	property p_off_idle;
		!analog_ctl.conv_power [*2] |-> !analog_ctl.conv_sample && !analog_ctl.conv_clk_en;
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("converter active while disabled");
	property p_ext_off;
		analog_ctl.in_source != 3'h0 |-> !analog_ctl.ext_connect && analog_ctl.pin_analog == 12'h000;
	endproperty
	a_ext_off: assert property (p_ext_off) else $error("external path on with internal source");
	property p_pin_sel;
		$onehot0(analog_ctl.pin_analog) && (analog_ctl.pin_analog == 12'h000 || analog_ctl.ext_connect);
	endproperty
	a_pin_sel: assert property (p_pin_sel) else $error("channel connection not one-hot");
	property p_ref_pin;
		analog_ctl.ref_pin_connect == (analog_ctl.ref_source == ACR_REF_PIN);
	endproperty
	a_ref_pin: assert property (p_ref_pin) else $error("reference pin path wrong");
endmodule : acr_checker
bind acr_ctrl acr_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.analog_ctl, .conv_irq_req);
`default_nettype wire

// *** tb/test_adc_control_register_set.sv ***
// Self-checking bench for the converter control register set.
`timescale 1ns/10ps
`default_nettype none
module test_adc_control_register_set;
	import acr_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        conv_done, pready, pslverr, conv_irq_req, e;
	logic [7:0]  paddr = 8'h00, extra = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic [11:0] conv_data, value = 12'h000, last = 12'h000;
	int          miscompares = 0, compares = 0;
	acr_analog_t analog_ctl;
	always #5 pclk = ~pclk;
	acr_ctrl #(.CONV_LEN(2)) u_dut (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .conv_done, .conv_data, .analog_ctl, .conv_irq_req);
	acr_core_model #(.LEN(2)) u_core (.pclk, .presetn, .ctl(analog_ctl), .value, .extra, .conv_done, .conv_data);
	task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
		compares++;
		if (g !== x) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", n, x, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20) miscompares++;
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		repeat (2) @(posedge pclk);
	endtask : apb
	task automatic res(input logic j);
		logic [15:0] x;
		x = j ? {4'h0, last} : {last, 4'h0};
		apb(1'b0, ADDR_RESH, 8'h00);
		chk("result_high", {24'h0, x[15:8]}, r);
		apb(1'b0, ADDR_RESL, 8'h00);
		chk("result_low", {24'h0, x[7:0]}, r);
	endtask : res
	task automatic t_reset;
		for (int i = 0; i < 7; i++) begin
			apb(1'b0, 8'(i * 4), 8'h00);
			chk("reset_value", 32'h0, r);
		end
		apb(1'b0, 8'h1C, 8'h00);
		chk("unmapped_err", 32'h1, {31'h0, e});
	endtask : t_reset
	task automatic t_mask;
		logic [7:0] a [4] = '{ADDR_BGAP, ADDR_CTRL0, ADDR_CTRL1, ADDR_CTRL2};
		logic [7:0] m [4] = '{BG_WMASK, 8'h9F, C1_WMASK, C2_WMASK};
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, a[i], (i == 1) ? 8'hDF : 8'hFF);
			apb(1'b0, a[i], 8'h00);
			chk("write_mask", {24'h0, m[i]}, r);
			apb(1'b1, a[i], (i == 0) ? 8'h01 : 8'h00);
		end
	endtask : t_mask
	task automatic t_routes;
		logic [2:0] s;
		logic [1:0] dv;
		apb(1'b1, ADDR_BGAP, 8'h01);
		apb(1'b1, ADDR_CTRL2, 8'h90);
		apb(1'b1, ADDR_CTRL0, 8'h01);
		for (int c = 0; c < 16; c++) begin
			s = (c == 0 || c == 4 || c > 11) ? 3'd0 : (c < 4) ? 3'd1 : (c < 8) ? 3'd2 : 3'd3;
			dv = 2'((c < 4) ? c - 1 : c - 5);
			apb(1'b1, ADDR_CTRL1, 8'(c << 4));
			chk("in_source", {29'h0, s}, {29'h0, analog_ctl.in_source});
			chk("ext_connect", {31'h0, s == 3'd0}, {31'h0, analog_ctl.ext_connect});
			if (s == 3'd1 || s == 3'd2) chk("in_divide", {30'h0, dv}, {30'h0, analog_ctl.in_divide});
		end
		apb(1'b1, ADDR_CTRL1, 8'h00);
		for (int c = 0; c < 16; c++) begin
			if (c inside {2, 3, 4, 10}) continue;
			apb(1'b1, ADDR_CTRL0, 8'(c));
			chk("pin_select", (c < 12) ? 32'(1 << c) : 32'h0, {20'h0, analog_ctl.pin_analog});
			chk("ext_channel", 32'(c), {28'h0, analog_ctl.ext_channel});
		end
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, ADDR_CTRL2, 8'(8'h90 | (c << 2) | c));
			chk("ref_source", (c < 2) ? c : 2, {30'h0, analog_ctl.ref_source});
			chk("ref_pin", c == 1, {31'h0, analog_ctl.ref_pin_connect});
			chk("amp_ctl", {27'h0, 1'b1, 2'(c), 2'b11}, {27'h0, analog_ctl.amp_enable, analog_ctl.amp_gain,
				analog_ctl.amp_bandgap, analog_ctl.bandgap_enable});
		end
		apb(1'b1, ADDR_CTRL2, 8'h00);
	endtask : t_routes
	task automatic t_div;
		int n;
		apb(1'b1, ADDR_CTRL0, 8'h20);
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, ADDR_CTRL1, 8'(k));
			for (int w = 0; w < 3; w++) begin
				n = 0;
				do begin
					@(posedge pclk);
					n++;
				end while (analog_ctl.conv_clk_en !== 1'b1 && n < 300);
			end
			chk("tick_period", 32'(1 << k), 32'(n));
		end
		apb(1'b1, ADDR_CTRL1, 8'h00);
	endtask : t_div
	task automatic t_conv(input logic j, input logic [11:0] v, input logic [7:0] x);
		int n;
		value <= v;
		extra <= x;
		last = v;
		apb(1'b1, ADDR_CTRL0, {3'b001, j, 4'h0});
		apb(1'b1, ADDR_CTRL0, {3'b101, j, 4'h0});
		apb(1'b1, ADDR_CTRL0, {3'b001, j, 4'h0});
		apb(1'b0, ADDR_CTRL0, 8'h00);
		chk("busy_set", {24'h0, 3'b011, j, 4'h0}, r);
		chk("conv_power", 32'h1, {31'h0, analog_ctl.conv_power});
		if (x != 8'h00) begin
			chk("conv_sample", 32'h1, {31'h0, analog_ctl.conv_sample});
			apb(1'b1, ADDR_CTRL0, {3'b101, j, 4'h0});
			apb(1'b1, ADDR_CTRL0, {3'b001, j, 4'h0});
		end
		n = 0;
		while (conv_irq_req !== 1'b1 && n < 500) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 500) miscompares++;
		apb(1'b0, ADDR_CTRL0, 8'h00);
		chk("busy_clear", {24'h0, 3'b001, j, 4'h0}, r);
		res(j);
		apb(1'b0, ADDR_STATUS, 8'h00);
		chk("irq_flag", 32'h1, r);
		apb(1'b1, ADDR_STATUS, 8'h01);
		apb(1'b0, ADDR_STATUS, 8'h00);
		chk("irq_clear", 32'h0, r);
	endtask : t_conv
	task automatic t_disabled;
		value <= 12'h111;
		extra <= 8'd200;
		apb(1'b1, ADDR_CTRL0, 8'hA0);
		apb(1'b1, ADDR_CTRL0, 8'h20);
		apb(1'b1, ADDR_CTRL0, 8'h80);
		apb(1'b1, ADDR_CTRL0, 8'h00);
		apb(1'b0, ADDR_CTRL0, 8'h00);
		chk("busy_off", 32'h0, r);
		chk("conv_power", 32'h0, {31'h0, analog_ctl.conv_power});
		repeat (30) @(posedge pclk);
		res(1'b0);
	endtask : t_disabled
	task automatic end_of_test;
		if (miscompares == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_mask();
		t_routes();
		t_div();
		t_conv(1'b0, 12'hA5C, 8'h00);
		t_conv(1'b1, 12'h3E7, 8'd40);
		t_disabled();
		end_of_test();
	end
	initial begin
		#100000;
		miscompares++;
		end_of_test();
	end
endmodule : test_adc_control_register_set
`default_nettype wire
